// file: core/avm_comp_mixer.sv
// one 8-bit component mixer with a nine-bit weight
// assumes the caller registers the result
`timescale 1ns/100ps
module avm_comp_mixer
  import avm_pkg::*;
(
  input wire logic [7:0] v1,
  input wire logic [7:0] v2,
  input wire logic [8:0] alpha,
  input wire logic [1:0] tfn,
  output logic [7:0] mix
);
  logic [16:0] p1;
  logic [16:0] p2;
  logic [17:0] sum;
  logic [8:0] fg;
  logic [9:0] bg;

  // rounding by half an lsb keeps 080h midpoints on the upper code
  always_comb begin
    p1 = 17'(alpha) * 17'(v1);
    p2 = 17'(ALPHA_UNITY - alpha) * 17'(v2);
    sum = 18'(p1) + 18'(p2) + 18'h00080;
    fg = 9'((18'(p1) + 18'h00080) >> 8);
    bg = 10'(fg) + 10'(v2);
    case (tfn)
      AVM_TFN_FORE: mix = fg[8] ? 8'hFF : fg[7:0];
      AVM_TFN_BACK: mix = (bg > 10'h0FF) ? 8'hFF : bg[7:0];
      default: mix = sum[15:8];
    endcase
  end
endmodule

// file: core/avm_mixer_top.sv
// alpha video mixer datapath with its microprocessor register port
// assumes pixel, alpha and control inputs synchronous to sys_clk
// Contract
// - capture nine alpha bits every pixel clock.
// - gain bit picks 8 or 9 bit mode; 0FF gives 256 or 255.
// - low alpha bits index a 256x8 remap table reachable via port.
// - alpha bit 8 forces first gain 256/256, second 0/256.
// - remap enable low bypasses the table, raw alpha drives weight.
// - fill color held in port registers 03, 04 and 05.
// - crosspoint routes one ordered pair AB, BA, BF, FB, FA or AF to mixers.
// - three 9-bit component mixers give a 256-step transition.
// - normal mode output is alpha v1 plus one-minus-alpha v2.
// - all six ordered dissolves selectable by register or pins.
// - enabled select pins steer the crosspoint every pixel.
// - transfer function picks normal, foreground or background key.
// - new alpha accepted every pixel with no rate restriction.
// - alpha path latency equals pixel path latency.
// - passthrough mode passes A or B unchanged while gate is low.
// - output shows mixer result or A or B crosspoint input.
// - formatter turns 444 into 16-bit 422, or passes 24 bits.
// - output updates on rising edge, high impedance when disabled.
// - preview takes A, B or mix, optional matrix, chroma format.
// - sleep bits power down converters and overlay memory.
// - register 7 bit 2 adds 21 unit pedestal; 110 sync on green.
// - both pixel buses are captured on the rising edge.
`timescale 1ns/100ps
module avm_mixer_top (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [23:0] first_pixel_input,
  input wire logic [23:0] second_pixel_input,
  input wire logic [8:0] alpha_in,
  input wire logic [2:0] crosspoint_select_pins,
  input wire logic passthrough_gate,
  input wire logic blank_n,
  input wire logic sync_n,
  input wire logic [2:0] up_addr,
  input wire logic up_cs_n,
  input wire logic up_wr_n,
  input wire logic up_rd_n,
  input wire logic [7:0] up_data_in,
  output logic [7:0] up_data_out,
  output logic up_data_oe,
  output logic [23:0] mix_out,
  output logic mix_out_oe,
  output logic [8:0] dac_g,
  output logic [8:0] dac_b,
  output logic [8:0] dac_r,
  output logic converter_sleep,
  output logic overlay_memory_sleep
);
  import avm_pkg::*;

  typedef struct packed {
    logic [23:0] a1;
    logic [23:0] b1;
    logic [8:0] al1;
    logic [2:0] xp1;
    logic gate1;
    logic [23:0] a2;
    logic [23:0] b2;
    logic [8:0] aeff;
    logic [2:0] xsel2;
    logic gate2;
    logic [23:0] output_drive_enable;
    logic phase;
    logic [8:0] dg;
    logic [8:0] db;
    logic [8:0] dr;
    logic [7:0] ctrl_addr;
    logic [7:0] wr_addr;
    logic [7:0] rd_addr;
    logic [7:0] mask;
    logic [7:0] mix_cfg;
    logic [7:0] xpt_cfg;
    logic [7:0] out_cfg;
    logic [7:0] fill0;
    logic [7:0] fill1;
    logic [7:0] fill2;
    logic [7:0] dac_cfg;
    logic [7:0] rdata;
    logic wr_d;
    logic rd_d;
  } avm_state_t;

  avm_state_t st_r;
  avm_state_t st_nxt;

  // remap table; contents are undefined until software loads them
  logic [7:0] remap_mem [0:255];
  logic remap_we;
  logic [7:0] remap_val;
  logic [47:0] pair;
  logic [23:0] v1;
  logic [23:0] v2;
  logic [23:0] mixed;
  logic wr_go;
  logic rd_go;

  // effective nine-bit weight from raw alpha and the remap entry
  function automatic logic [8:0] eff_alpha(input logic [8:0] al,
      input logic [7:0] lut, input logic lut_en, input logic gain8);
    logic [7:0] v;
    v = lut_en ? lut : al[7:0];
    if (al[8])
      eff_alpha = ALPHA_UNITY;
    else if (gain8 && v == ALPHA_FULL8)
      eff_alpha = ALPHA_UNITY;
    else
      eff_alpha = {1'b0, v};
  endfunction

  // ordered source pair {first, second} for a crosspoint code
  function automatic logic [47:0] xpt_pair(input logic [2:0] code,
      input logic [23:0] a, input logic [23:0] b, input logic [23:0] f);
    case (code)
      XPT_BA: xpt_pair = {b, a};
      XPT_BF: xpt_pair = {b, f};
      XPT_FB: xpt_pair = {f, b};
      XPT_FA: xpt_pair = {f, a};
      XPT_AF: xpt_pair = {a, f};
      default: xpt_pair = {a, b};
    endcase
  endfunction

  function automatic logic [7:0] clamp8(input logic signed [17:0] x);
    if (x < 0)
      clamp8 = 8'h00;
    else if (x > 18'sh000FF)
      clamp8 = 8'hFF;
    else
      clamp8 = x[7:0];
  endfunction

  // offset-binary luma/chroma to green, blue, red; coarse fixed point
  function automatic logic [23:0] ycc_to_gbr(input logic [23:0] p);
    logic signed [17:0] y;
    logic signed [17:0] cb;
    logic signed [17:0] cr;
    y = 18'sd0 + $signed({10'h000, p[23:16]});
    cb = $signed({10'h000, p[15:8]}) - 18'sh00080;
    cr = $signed({10'h000, p[7:0]}) - 18'sh00080;
    ycc_to_gbr = {clamp8(y - ((cb * 18'sd88 + cr * 18'sd183) >>> 8)),
                  clamp8(y + ((cb * 18'sd454) >>> 8)),
                  clamp8(y + ((cr * 18'sd359) >>> 8))};
  endfunction

  // converter code in current units: pedestal on active video, sync on g
  function automatic logic [8:0] dac_code(input logic [7:0] d,
      input logic setup, input logic blank_hi, input logic add_sync);
    logic [8:0] v;
    v = blank_hi ? (9'(d) + (setup ? PEDESTAL_IU : 9'h000)) : 9'h000;
    dac_code = v + (add_sync ? SYNC_IU : 9'h000);
  endfunction

  function automatic logic [7:0] ctrl_read(input avm_state_t s);
    case (s.ctrl_addr[3:0])
      REG_MIX_CFG: ctrl_read = s.mix_cfg;
      REG_XPT_CFG: ctrl_read = s.xpt_cfg;
      REG_OUT_CFG: ctrl_read = s.out_cfg;
      REG_FILL_0: ctrl_read = s.fill0;
      REG_FILL_1: ctrl_read = s.fill1;
      REG_FILL_2: ctrl_read = s.fill2;
      REG_DAC_CFG: ctrl_read = s.dac_cfg;
      default: ctrl_read = 8'h00;
    endcase
  endfunction

  // crosspoint and three component mixers on stage two data
  assign remap_val = remap_mem[st_r.al1[7:0]];
  assign pair = xpt_pair(st_r.xsel2, st_r.a2, st_r.b2,
                         {st_r.fill0, st_r.fill1, st_r.fill2});
  assign v1 = pair[47:24];
  assign v2 = pair[23:0];

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_comp
      // one mixer per colour component
      avm_comp_mixer u_mix (
        .v1(v1[g*8 +: 8]),
        .v2(v2[g*8 +: 8]),
        .alpha(st_r.aeff),
        .tfn(st_r.mix_cfg[MIX_TFN_LSB +: 2]),
        .mix(mixed[g*8 +: 8])
      );
    end
  endgenerate

  // port strobes act once, on the first cycle of each low pulse
  assign wr_go = !up_cs_n && !up_wr_n && !st_r.wr_d;
  assign rd_go = !up_cs_n && !up_rd_n && !st_r.rd_d;
  assign remap_we = wr_go && up_addr == PORT_RAM_DATA &&
                    st_r.ctrl_addr[7:6] == RAM_SEL_REMAP;

  // next state of pipeline and registers
  always_comb begin
    logic [23:0] sel;
    logic [23:0] pv;
    logic [23:0] pv_a;
    logic [23:0] pv_b;
    sel = 24'h000000;
    pv = 24'h000000;
    pv_a = st_r.a2;
    pv_b = st_r.b2;
    st_nxt = st_r;
    // stage one registers pixels and alpha together
    st_nxt.a1 = first_pixel_input;
    st_nxt.b1 = second_pixel_input;
    st_nxt.al1 = alpha_in;
    st_nxt.xp1 = crosspoint_select_pins;
    st_nxt.gate1 = passthrough_gate;
    // stage two: pixels advance one stage as alpha is resolved
    st_nxt.a2 = st_r.a1;
    st_nxt.b2 = st_r.b1;
    st_nxt.gate2 = st_r.gate1;
    st_nxt.aeff = eff_alpha(st_r.al1, remap_val,
                            st_r.mix_cfg[MIX_REMAP_EN_BIT],
                            st_r.mix_cfg[MIX_GAIN8_BIT]);
    // pins win over the register code when enabled
    st_nxt.xsel2 = st_r.xpt_cfg[XPT_PIN_EN_BIT] ? st_r.xp1 :
                   st_r.xpt_cfg[XPT_CODE_LSB +: 3];
    // output selection and formatter
    case (st_r.out_cfg[OUT_SRC_LSB +: 2])
      AVM_SRC_A: sel = st_r.a2;
      AVM_SRC_B: sel = st_r.b2;
      default: sel = mixed;
    endcase
    if (st_r.out_cfg[OUT_PASS_BIT] && !st_r.gate2) begin
      // raw data, not reformatted, so embedded codes survive
      st_nxt.output_drive_enable = st_r.out_cfg[OUT_PASS_SRC_BIT] ? st_r.b2 : st_r.a2;
    end else if (st_r.out_cfg[OUT_FMT_BIT]) begin
      st_nxt.output_drive_enable = {sel[23:16], st_r.phase ? sel[7:0] : sel[15:8],
                     8'h00};
    end else begin
      st_nxt.output_drive_enable = sel;
    end
    st_nxt.phase = st_r.out_cfg[OUT_FMT_BIT] ? !st_r.phase : 1'b0;
    // preview converters
    if (st_r.dac_cfg[DAC_FRM_BIT]) begin
      pv_a = st_r.a2 ^ 24'h008080;
      pv_b = st_r.b2 ^ 24'h008080;
    end
    case (st_r.dac_cfg[DAC_SRC_LSB +: 2])
      AVM_SRC_A: pv = pv_a;
      AVM_SRC_B: pv = pv_b;
      default: pv = mixed;
    endcase
    if (st_r.dac_cfg[DAC_MATRIX_BIT])
      pv = ycc_to_gbr(pv);
    if (st_r.dac_cfg[DAC_SLEEP_BIT]) begin
      // sleeping converters draw no current
      st_nxt.dg = 9'h000;
      st_nxt.db = 9'h000;
      st_nxt.dr = 9'h000;
    end else begin
      st_nxt.dg = dac_code(pv[23:16], st_r.dac_cfg[DAC_SETUP_BIT],
                           blank_n, sync_n);
      st_nxt.db = dac_code(pv[15:8], st_r.dac_cfg[DAC_SETUP_BIT],
                           blank_n, 1'b0);
      st_nxt.dr = dac_code(pv[7:0], st_r.dac_cfg[DAC_SETUP_BIT],
                           blank_n, 1'b0);
    end
    // microprocessor writes
    st_nxt.wr_d = !up_cs_n && !up_wr_n;
    st_nxt.rd_d = !up_cs_n && !up_rd_n;
    if (wr_go) begin
      case (up_addr)
        PORT_WR_ADDR: st_nxt.wr_addr = up_data_in;
        PORT_RD_ADDR: st_nxt.rd_addr = up_data_in;
        PORT_CTRL_ADDR: st_nxt.ctrl_addr = up_data_in;
        PORT_MASK: st_nxt.mask = up_data_in;
        PORT_RAM_DATA: st_nxt.wr_addr = st_r.wr_addr + 8'h01;
        PORT_CTRL_DATA: begin
          case (st_r.ctrl_addr[3:0])
            REG_MIX_CFG: st_nxt.mix_cfg = up_data_in;
            REG_XPT_CFG: st_nxt.xpt_cfg = up_data_in;
            REG_OUT_CFG: st_nxt.out_cfg = up_data_in;
            REG_FILL_0: st_nxt.fill0 = up_data_in;
            REG_FILL_1: st_nxt.fill1 = up_data_in;
            REG_FILL_2: st_nxt.fill2 = up_data_in;
            REG_DAC_CFG: st_nxt.dac_cfg = up_data_in;
            default: st_nxt.rdata = st_r.rdata;
          endcase
        end
        default: st_nxt.rdata = st_r.rdata;
      endcase
    end
    // reads capture on the strobe; ram reads step the read address
    if (rd_go) begin
      case (up_addr)
        PORT_WR_ADDR: st_nxt.rdata = st_r.wr_addr;
        PORT_RD_ADDR: st_nxt.rdata = st_r.rd_addr;
        PORT_CTRL_ADDR: st_nxt.rdata = st_r.ctrl_addr;
        PORT_MASK: st_nxt.rdata = st_r.mask;
        PORT_CTRL_DATA: st_nxt.rdata = ctrl_read(st_r);
        PORT_RAM_DATA: begin
          st_nxt.rdata = (st_r.ctrl_addr[7:6] == RAM_SEL_REMAP) ?
                         remap_mem[st_r.rd_addr] : 8'h00;
          st_nxt.rd_addr = st_r.rd_addr + 8'h01;
        end
        default: st_nxt.rdata = 8'h00;
      endcase
    end
    if (!rst_n) begin
      st_nxt = '0;
      st_nxt.mask = MASK_RESET;
      st_nxt.mix_cfg = CTRL_RESET;
      st_nxt.out_cfg = CTRL_RESET;
    end
  end

  always_ff @(posedge sys_clk) begin
    st_r <= st_nxt;
  end

  // table writes use the write address before its increment
  always_ff @(posedge sys_clk) begin
    if (remap_we)
      remap_mem[st_r.wr_addr] <= up_data_in;
  end

  // outputs; the pad resolves high impedance from the enable
  assign mix_out = st_r.output_drive_enable;
  assign mix_out_oe = st_r.out_cfg[OUT_DRIVE_BIT];
  assign up_data_out = st_r.rdata;
  assign up_data_oe = !up_cs_n && !up_rd_n;
  assign dac_g = st_r.dg;
  assign dac_b = st_r.db;
  assign dac_r = st_r.dr;
  assign converter_sleep = st_r.dac_cfg[DAC_SLEEP_BIT];
  assign overlay_memory_sleep = st_r.dac_cfg[DAC_OVL_BIT];

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_unity_key: assert property (alpha_in[8] |-> ##2
    st_r.aeff == ALPHA_UNITY) else $error("alpha bit 8 not unity");
  a_bypass_raw: assert property (
    !st_r.mix_cfg[MIX_REMAP_EN_BIT] &&
    !st_r.mix_cfg[MIX_GAIN8_BIT] && !alpha_in[8] && up_cs_n |-> ##2
    st_r.aeff == {1'b0, $past(alpha_in[7:0], 2)})
    else $error("bypassed alpha differs from input");
  a_gain_eight: assert property (alpha_in == 9'h0FF && up_cs_n &&
    !st_r.mix_cfg[MIX_REMAP_EN_BIT] && st_r.mix_cfg[MIX_GAIN8_BIT] |->
    ##2 st_r.aeff == ALPHA_UNITY) else $error("8-bit 0FF not unity");
  a_gain_nine: assert property (alpha_in == 9'h0FF && up_cs_n &&
    !st_r.mix_cfg[MIX_REMAP_EN_BIT] && !st_r.mix_cfg[MIX_GAIN8_BIT] |->
    ##2 st_r.aeff == 9'h0FF) else $error("9-bit 0FF not 255");
  // the pad enable must follow the drive bit from the cycle it is written
  a_out_hiz: assert property (
    wr_go && up_addr == PORT_CTRL_DATA &&
    st_r.ctrl_addr[3:0] == REG_OUT_CFG |=>
    mix_out_oe == $past(up_data_in[OUT_DRIVE_BIT]))
    else $error("output enable not following drive bit");
  a_pass_data: assert property (st_r.out_cfg[OUT_PASS_BIT] &&
    !st_r.out_cfg[OUT_PASS_SRC_BIT] && !passthrough_gate && up_cs_n
    ##1 up_cs_n ##1 up_cs_n |-> ##1
    mix_out == $past(first_pixel_input, 3))
    else $error("passthrough data altered");
  a_mix_unity: assert property (
    st_r.aeff == ALPHA_UNITY && up_cs_n &&
    st_r.mix_cfg[MIX_TFN_LSB +: 2] == AVM_TFN_NORMAL &&
    {st_r.out_cfg[5:4], st_r.out_cfg[2:0]} == 5'h00 |-> ##1
    mix_out == $past(v1))
    else $error("unity weight did not select first source");
  a_xpt_pins: assert property (st_r.xpt_cfg[XPT_PIN_EN_BIT] &&
    up_cs_n ##1 up_cs_n |-> ##1
    st_r.xsel2 == $past(crosspoint_select_pins, 2))
    else $error("select pins not steering crosspoint");
  a_fill_write: assert property (
    wr_go && up_addr == PORT_CTRL_DATA &&
    st_r.ctrl_addr[3:0] == REG_FILL_0 |=> st_r.fill0 == $past(up_data_in))
    else $error("fill register not written");

  c_unity_key: cover property (alpha_in[8] ##2 st_r.aeff == ALPHA_UNITY);
  c_pins_used: cover property (st_r.xpt_cfg[XPT_PIN_EN_BIT] &&
    st_r.xsel2 == XPT_FA);
  c_pass_on: cover property (st_r.out_cfg[OUT_PASS_BIT] && !st_r.gate2);
  c_fmt_422: cover property (st_r.out_cfg[OUT_FMT_BIT] ##1
    st_r.out_cfg[OUT_FMT_BIT]);
endmodule

// file: core/avm_pkg.sv
// shared constants and types of the alpha video mixer
// assumes one pixel clock and the 3-bit microprocessor address space
package avm_pkg;

  // microprocessor port addresses
  localparam logic [2:0] PORT_WR_ADDR = 3'h0;
  localparam logic [2:0] PORT_RAM_DATA = 3'h1;
  localparam logic [2:0] PORT_RD_ADDR = 3'h3;
  localparam logic [2:0] PORT_CTRL_DATA = 3'h5;
  localparam logic [2:0] PORT_MASK = 3'h6;
  localparam logic [2:0] PORT_CTRL_ADDR = 3'h7;

  // control register indices, low four bits of the control address
  localparam logic [3:0] REG_MIX_CFG = 4'h0;
  localparam logic [3:0] REG_XPT_CFG = 4'h1;
  localparam logic [3:0] REG_OUT_CFG = 4'h2;
  localparam logic [3:0] REG_FILL_0 = 4'h3;
  localparam logic [3:0] REG_FILL_1 = 4'h4;
  localparam logic [3:0] REG_FILL_2 = 4'h5;
  localparam logic [3:0] REG_DAC_CFG = 4'h7;

  // ram select in the two top bits of the control address
  localparam logic [1:0] RAM_SEL_REMAP = 2'h3;

  // field positions
  localparam int MIX_GAIN8_BIT = 0;
  localparam int MIX_REMAP_EN_BIT = 1;
  localparam int MIX_TFN_LSB = 2;
  localparam int XPT_CODE_LSB = 0;
  localparam int XPT_PIN_EN_BIT = 3;
  localparam int OUT_SRC_LSB = 0;
  localparam int OUT_FMT_BIT = 2;
  localparam int OUT_DRIVE_BIT = 3;
  localparam int OUT_PASS_BIT = 4;
  localparam int OUT_PASS_SRC_BIT = 5;
  localparam int DAC_SRC_LSB = 0;
  localparam int DAC_SETUP_BIT = 2;
  localparam int DAC_FRM_BIT = 3;
  localparam int DAC_SLEEP_BIT = 4;
  localparam int DAC_OVL_BIT = 5;
  localparam int DAC_MATRIX_BIT = 6;

  // reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'hFF;

  // arithmetic constants
  localparam logic [8:0] ALPHA_UNITY = 9'h100;
  localparam logic [7:0] ALPHA_FULL8 = 8'hFF;
  localparam logic [8:0] PEDESTAL_IU = 9'h015;
  localparam logic [8:0] SYNC_IU = 9'h06E;
  localparam logic [7:0] CHROMA_MID = 8'h80;

  // crosspoint codes: first source then second source
  localparam logic [2:0] XPT_AB = 3'h0;
  localparam logic [2:0] XPT_BA = 3'h1;
  localparam logic [2:0] XPT_BF = 3'h2;
  localparam logic [2:0] XPT_FB = 3'h3;
  localparam logic [2:0] XPT_FA = 3'h4;
  localparam logic [2:0] XPT_AF = 3'h5;

  typedef enum logic [1:0] {
    AVM_TFN_NORMAL, AVM_TFN_FORE, AVM_TFN_BACK
  } avm_tfn_t;

  typedef enum logic [1:0] {
    AVM_SRC_MIX, AVM_SRC_A, AVM_SRC_B
  } avm_src_t;

endpackage

// file: tb/avm_pixel_src.sv
// upstream video source model: pixels, alpha, crosspoint code and gate
// seeds its own generator once, at the first clock edge, before any test
`timescale 1ns/100ps
module avm_pixel_src (
  input wire logic sys_clk,
  output logic [23:0] pix_a,
  output logic [23:0] pix_b,
  output logic [8:0] alpha,
  output logic [2:0] xpt_pins,
  output logic gate
);
  logic seeded = 1'b0;

  initial begin
    pix_a = 24'h000000;
    pix_b = 24'h000000;
    alpha = 9'h000;
    xpt_pins = 3'h0;
    gate = 1'b1;
  end

  // a fresh value every pixel, no rate limit on alpha changes
  // top-end values of alpha, 0FF and bit 8 set, are forced often since random ones rarely hit 0FF
  // the seed must be given in this process, whose generator feeds the pins
  always @(posedge sys_clk) begin
    if (!seeded)
      void'($urandom(32'hE52D));
    seeded = 1'b1;
    pix_a <= 24'($urandom);
    pix_b <= 24'($urandom);
    xpt_pins <= 3'($urandom);
    gate <= 1'($urandom);
    case ($urandom % 4)
      0: alpha <= 9'h0FF;
      1: alpha <= {1'b1, 8'($urandom)};
      default: alpha <= 9'($urandom);
    endcase
  end
endmodule

// file: tb/tb.sv
// self-checking bench of the alpha video mixer with a reference model
// assumes the register port contract and a 3-edge pixel latency
`timescale 1ns/100ps
module tb;
  import avm_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [23:0] pa, pb, mix_out, ev;
  logic [8:0] alpha_in;
  logic [2:0] pins;
  logic [2:0] up_addr = 3'h0;
  logic gate, mix_out_oe, cv_sl, ov_sl;
  logic up_cs_n = 1'b1;
  logic up_wr_n = 1'b1;
  logic up_rd_n = 1'b1;
  logic chk_on = 1'b0;
  logic [7:0] up_data_in = 8'h00;
  logic [7:0] up_data_out;
  logic blank_n = 1'b1;
  logic sync_n = 1'b1;
  logic up_oe;
  logic fph = 1'b0;
  logic [8:0] dac_g, dac_b, dac_r;
  logic [26:0] edac, dq;
  int error_cnt = 0;
  int compares = 0;
  int cyc = 0;
  int gain8 = 0, remap = 0, tfn = 0, xcode = 0, pin_en = 0;
  int osrc = 0, drive = 1, pass_on = 0, pass_src = 0;
  int fmt = 0, dsrc = 0, dset = 0, dfrm = 0, dslp = 0, dovl = 0;
  int fill[3];
  int tbl[256];
  logic [23:0] expq[$];
  logic [26:0] dacq[$];

  always #5 sys_clk = ~sys_clk;

  avm_pixel_src src (.sys_clk(sys_clk), .pix_a(pa), .pix_b(pb),
    .alpha(alpha_in), .xpt_pins(pins), .gate(gate));

  avm_mixer_top DUT (.sys_clk(sys_clk), .rst_n(rst_n),
    .first_pixel_input(pa), .second_pixel_input(pb), .alpha_in(alpha_in),
    .crosspoint_select_pins(pins), .passthrough_gate(gate),
    .blank_n(blank_n), .sync_n(sync_n), .up_addr(up_addr),
    .up_cs_n(up_cs_n), .up_wr_n(up_wr_n), .up_rd_n(up_rd_n),
    .up_data_in(up_data_in), .up_data_out(up_data_out),
    .up_data_oe(up_oe), .mix_out(mix_out), .mix_out_oe(mix_out_oe),
    .dac_g(dac_g), .dac_b(dac_b), .dac_r(dac_r),
    .converter_sleep(cv_sl), .overlay_memory_sleep(ov_sl));

  // reference: weight, crosspoint pair, transfer function, output select
  function automatic logic [23:0] model(logic [23:0] a, logic [23:0] b,
      logic [8:0] al, logic [2:0] pn, logic g, output logic [26:0] de);
    int w, code, v1, v2, m, dv;
    int p1[8] = '{0, 1, 1, 2, 2, 0, 0, 0};
    int p2[8] = '{1, 0, 2, 1, 0, 2, 1, 1};
    logic [23:0] s[3];
    logic [23:0] r;
    logic [23:0] pv;
    s[0] = a;
    s[1] = b;
    s[2] = {8'(fill[0]), 8'(fill[1]), 8'(fill[2])};
    w = remap ? tbl[al[7:0]] : int'(al[7:0]);
    if (gain8 != 0 && w == 255) w = 256;
    if (al[8]) w = 256;
    code = pin_en ? int'(pn) : xcode;
    for (int i = 0; i < 3; i++) begin
      v1 = s[p1[code]][8*i +: 8];
      v2 = s[p2[code]][8*i +: 8];
      if (tfn == 1) m = (w * v1 + 128) >> 8;
      else if (tfn == 2) m = ((w * v1 + 128) >> 8) + v2;
      else m = (w * v1 + (256 - w) * v2 + 128) >> 8;
      r[8*i +: 8] = (m > 255) ? 8'hFF : 8'(m);
    end
    // preview converter codes in current units, sync only on green
    pv = (dsrc == 1) ? a : (dsrc == 2) ? b : r;
    if (dfrm != 0 && (dsrc == 1 || dsrc == 2)) pv = pv ^ 24'h008080;
    for (int i = 0; i < 3; i++) begin
      dv = blank_n ? int'(pv[8*i +: 8]) + 21 * dset : 0;
      if (i == 2 && sync_n) dv = dv + 110;
      de[9*i +: 9] = (dslp != 0) ? 9'h000 : 9'(dv);
    end
    if (pass_on != 0 && !g) return pass_src ? b : a;
    if (osrc == 1) return a;
    if (osrc == 2) return b;
    return r;
  endfunction

  task automatic summarize;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk_reg(logic [7:0] got, logic [7:0] e);
    compares++;
    if (got !== e) begin
      error_cnt++;
      $display("MISMATCH %0t reg got %h exp %h", $time, got, e);
    end
  endtask

  task automatic chk_pix(logic [23:0] got, logic [23:0] e);
    compares++;
    if (got !== e) begin
      error_cnt++;
      $display("MISMATCH %0t pixel got %h exp %h", $time, got, e);
    end
  endtask

  task automatic chk_dac(logic [26:0] got, logic [26:0] e);
    compares++;
    if (got !== e) begin
      error_cnt++;
      $display("MISMATCH %0t converter got %h exp %h", $time, got, e);
    end
  endtask

  // strobe held one cycle, released, then one idle edge for spacing
  task automatic wr(logic [2:0] a, logic [7:0] d);
    @(posedge sys_clk);
    up_addr <= a;
    up_data_in <= d;
    up_cs_n <= 1'b0;
    up_wr_n <= 1'b0;
    @(posedge sys_clk);
    up_cs_n <= 1'b1;
    up_wr_n <= 1'b1;
    @(posedge sys_clk);
  endtask

  task automatic rd(logic [2:0] a, logic [7:0] e);
    @(posedge sys_clk);
    up_addr <= a;
    up_cs_n <= 1'b0;
    up_rd_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk_reg({7'h0, up_oe}, 8'h01);
    up_cs_n <= 1'b1;
    up_rd_n <= 1'b1;
    #1 chk_reg(up_data_out, e);
    chk_reg({7'h0, up_oe}, 8'h00);
  endtask

  task automatic cw(logic [3:0] idx, logic [7:0] d);
    wr(PORT_CTRL_ADDR, {4'h0, idx});
    wr(PORT_CTRL_DATA, d);
  endtask

  // checks paused while settings change, pipeline drains before resuming
  task automatic setcfg(int n);
    chk_on = 1'b0;
    cw(REG_MIX_CFG, {4'h0, 2'(tfn), 1'(remap), 1'(gain8)});
    cw(REG_XPT_CFG, {4'h0, 1'(pin_en), 3'(xcode)});
    cw(REG_DAC_CFG, {2'h0, 1'(dovl), 1'(dslp), 1'(dfrm), 1'(dset),
      2'(dsrc)});
    cw(REG_OUT_CFG, {2'h0, 1'(pass_src), 1'(pass_on), 1'(drive), 1'(fmt),
      2'(osrc)});
    fph = 1'b0; // first formatted output carries cb
    repeat (5) @(posedge sys_clk);
    chk_on = 1'b1;
    repeat (n) @(posedge sys_clk);
  endtask

  // expected result of each captured pixel, compared two edges later
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      expq.delete();
      dacq.delete();
    end else begin
      expq.push_back(model(pa, pb, alpha_in, pins, gate, edac));
      dacq.push_back(edac);
    end
  end

  // the 422 formatter alternates cb and cr on every output clock
  always @(negedge sys_clk) begin
    if (expq.size() == 3) begin
      ev = expq.pop_front();
      dq = dacq.pop_front();
      if (fmt != 0) ev = {ev[23:16], fph ? ev[7:0] : ev[15:8], 8'h00};
      if (chk_on) chk_pix(mix_out, ev);
      if (chk_on) chk_dac({dac_g, dac_b, dac_r}, dq);
    end
    fph = ~fph;
  end

  // hang guard well above the expected run of about 4500 cycles
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      summarize();
    end
  end

  initial begin
    repeat (9) @(posedge sys_clk);
    #1 chk_pix(mix_out, 24'h000000);
    @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(PORT_MASK, MASK_RESET);
    for (int i = 0; i < 3; i++) begin
      fill[i] = 'h3C + 'h41 * i;
      cw(4'(REG_FILL_0 + i), 8'(fill[i]));
      wr(PORT_CTRL_ADDR, 8'(REG_FILL_0 + i));
      rd(PORT_CTRL_DATA, 8'(fill[i]));
    end
    rd(3'h2, 8'h00);
    // every function, pair code and gain mode, random pixels and alpha
    for (int t = 0; t < 4; t++)
      for (int x = 0; x < 8; x++)
        for (int g = 0; g < 2; g++) begin
          tfn = t;
          xcode = x;
          gain8 = g;
          setcfg(10);
        end
    chk_reg({7'h0, mix_out_oe}, 8'h01);
    wr(PORT_CTRL_ADDR, 8'hC0);
    wr(PORT_WR_ADDR, 8'h00);
    for (int i = 0; i < 256; i++) begin
      tbl[i] = (i * 37 + 11) % 256;
      wr(PORT_RAM_DATA, 8'(tbl[i]));
    end
    wr(PORT_RD_ADDR, 8'h10);
    rd(PORT_RAM_DATA, 8'(tbl[16]));
    rd(PORT_RAM_DATA, 8'(tbl[17]));
    tfn = 0;
    xcode = 0;
    remap = 1;
    setcfg(300);
    remap = 0;
    pin_en = 1;
    setcfg(200);
    pin_en = 0;
    for (int o = 1; o < 3; o++) begin
      osrc = o;
      setcfg(30);
    end
    osrc = 0;
    fmt = 1;
    setcfg(40);
    fmt = 0;
    dsrc = 1;
    dset = 1;
    dfrm = 1;
    sync_n <= 1'b0;
    setcfg(40);
    dsrc = 2;
    dfrm = 0;
    sync_n <= 1'b1;
    blank_n <= 1'b0;
    setcfg(40);
    blank_n <= 1'b1;
    pass_on = 1;
    for (int p = 0; p < 2; p++) begin
      pass_src = p;
      setcfg(50);
    end
    drive = 0;
    setcfg(5);
    chk_reg({7'h0, mix_out_oe}, 8'h00);
    dslp = 1;
    dovl = 1;
    setcfg(20);
    chk_reg({6'h0, cv_sl, ov_sl}, 8'h03);
    dovl = 0;
    setcfg(20);
    chk_reg({6'h0, cv_sl, ov_sl}, 8'h02);
    summarize();
  end
endmodule
